// *** verilog/sram_tap.sv ***
// module: boundary-scan test port of the sram with an apb view of its state
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sram_tap (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic [tap_pkg::APB_AW-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  // test port pins
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  output var  logic                         tdo_out,
  output var  logic                         tdo_oe,
  // sram side
  input  wire logic [tap_pkg::BSR_LEN-1:0]  pin_ring,
  output var  logic                         sram_hiz
);

  // -------------------------------------------------------------------------
  // pin sampling and test-clock edge detection
  // -------------------------------------------------------------------------
  tap_pkg::pins_type      raw_pins;
  tap_pkg::pins_type      pins;
  logic                   tck_prev;
  logic                   tck_rise;
  logic                   tck_fall;
  tap_pkg::tap_state_type state;

  assign raw_pins = '{tck: tck, tms: tms, tdi: tdi};

  pin_filter #(
    .WIDTH ($bits(tap_pkg::pins_type))
  ) u_pin_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw_pins),
    .level   (pins)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pins.tck;
    end
  end

  assign tck_rise = pins.tck & ~tck_prev;
  assign tck_fall = ~pins.tck & tck_prev;

  tap_fsm u_tap_fsm (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (tck_rise),
    .tms     (pins.tms),
    .state   (state)
  );

  // -------------------------------------------------------------------------
  // instruction decode
  // -------------------------------------------------------------------------
  // reserved codes are not expected; they fall through to the bypass path
  function automatic logic uses_bsr(input logic [2:0] code);
    uses_bsr = (code == tap_pkg::INSTR_EXTEST) || (code == tap_pkg::INSTR_SAMPLE_Z) ||
               (code == tap_pkg::INSTR_SAMPLE);
  endfunction : uses_bsr

  logic [2:0]                  instr;
  logic [2:0]                  ir_shift;
  logic                        bypass_bit;
  logic [tap_pkg::ID_LEN-1:0]  id_shift;
  logic [tap_pkg::BSR_LEN-1:0] bsr_shift;
  logic [tap_pkg::BSR_LEN-1:0] last_capture;
  logic [31:0]                 id_cfg;
  tap_pkg::id_word_type        id_word;
  logic                        serial_bit;

  // -------------------------------------------------------------------------
  // identification word
  // -------------------------------------------------------------------------
  always_comb begin
    id_word.revision = id_cfg[tap_pkg::ID_REVISION_LSB +: 4];
    id_word.depth    = id_cfg[tap_pkg::ID_DEPTH_LSB +: 5];
    id_word.width    = id_cfg[tap_pkg::ID_WIDTH_LSB +: 5];
    id_word.part     = id_cfg[tap_pkg::ID_PART_LSB +: 6];
    id_word.maker    = tap_pkg::MAKER_CODE;
    id_word.present  = 1'b1;
  end

  // -------------------------------------------------------------------------
  // instruction register
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_shift <= tap_pkg::IR_CAPTURE;
      instr    <= tap_pkg::IR_RESET;
    end else if (tck_rise) begin
      unique case (state)
        tap_pkg::st_reset:    instr    <= tap_pkg::IR_RESET;
        tap_pkg::st_cap_ir:   ir_shift <= tap_pkg::IR_CAPTURE;
        tap_pkg::st_shift_ir: ir_shift <= {pins.tdi, ir_shift[2:1]};
        tap_pkg::st_upd_ir:   instr    <= ir_shift;
        default:              ir_shift <= ir_shift;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // data registers: capture and shift; update has no preload effect
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_shift <= '0;
    end else if (tck_rise && (instr == tap_pkg::INSTR_IDCODE)) begin
      if (state == tap_pkg::st_cap_dr) begin
        id_shift <= id_word;
      end else if (state == tap_pkg::st_shift_dr) begin
        id_shift <= {pins.tdi, id_shift[tap_pkg::ID_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsr_shift    <= '0;
      last_capture <= '0;
    end else if (tck_rise && uses_bsr(instr)) begin
      if (state == tap_pkg::st_cap_dr) begin
        bsr_shift    <= pin_ring;
        last_capture <= pin_ring;
      end else if (state == tap_pkg::st_shift_dr) begin
        bsr_shift <= {pins.tdi, bsr_shift[tap_pkg::BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_bit <= 1'b0;
    end else if (tck_rise && (instr != tap_pkg::INSTR_IDCODE) && !uses_bsr(instr)) begin
      if (state == tap_pkg::st_cap_dr) begin
        bypass_bit <= 1'b0;
      end else if (state == tap_pkg::st_shift_dr) begin
        bypass_bit <= pins.tdi;
      end
    end
  end

  // -------------------------------------------------------------------------
  // serial output on the falling test-clock edge
  // -------------------------------------------------------------------------
  always_comb begin
    if (state == tap_pkg::st_shift_ir) begin
      serial_bit = ir_shift[0];
    end else if (instr == tap_pkg::INSTR_IDCODE) begin
      serial_bit = id_shift[0];
    end else if (uses_bsr(instr)) begin
      serial_bit = bsr_shift[0];
    end else begin
      serial_bit = bypass_bit;
    end
  end

  // driver floats outside shift states, so it comes up released after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= serial_bit;
      tdo_oe  <= (state == tap_pkg::st_shift_ir) || (state == tap_pkg::st_shift_dr);
    end
  end

  // sram outputs float while a high-impedance capture instruction is current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_hiz <= 1'b0;
    end else begin
      sram_hiz <= (instr == tap_pkg::INSTR_EXTEST) || (instr == tap_pkg::INSTR_SAMPLE_Z);
    end
  end

  // -------------------------------------------------------------------------
  // apb slave: zero wait states, answer in the first access cycle
  // -------------------------------------------------------------------------
  logic        apb_setup;
  logic        apb_write;
  logic        addr_ok;
  logic [31:0] next_prdata;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      tap_pkg::ADDR_STATUS:  next_prdata = {23'h000000, tdo_oe, sram_hiz, instr, state};
      tap_pkg::ADDR_IDWORD:  next_prdata = id_word;
      tap_pkg::ADDR_IDCFG:   next_prdata = id_cfg;
      tap_pkg::ADDR_CAPTURE: next_prdata = last_capture;
      default: begin
        next_prdata = 32'h00000000;
        addr_ok     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      prdata  <= (apb_setup && !pwrite) ? next_prdata : 32'h00000000;
    end
  end

  // only revision, depth, width and part fields are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_cfg <= tap_pkg::RESET_IDCFG;
    end else if (apb_write && (paddr == tap_pkg::ADDR_IDCFG)) begin
      id_cfg <= {pwdata[31:12], 12'h000};
    end
  end

endmodule : sram_tap
`default_nettype wire

// *** verilog/tap_pkg.sv ***
// package: constants, types and state encoding of the sram boundary-scan test port
//
// Behaviour
// - state machine steps on each test-clock rise using the mode-select level sampled then
// - code 000 captures pin ring, selects boundary register, floats all sram outputs
// - code 001 loads identification word and selects it; sram unaffected
// - code 010 captures pin ring, selects boundary register, floats sram output drivers
// - code 100 captures pin ring, selects boundary register; no preload, sram unaffected
// - code 111 selects the one-bit bypass register; sram unaffected
// - identification bits 31:28 hold the revision number
// - identification bits 27:23 encode memory depth
// - identification bits 22:18 encode data width
// - identification bits 17:12 hold a reserved part identifier
// - identification bits 11:1 hold the manufacturer code
// - identification bit 0 marks an identification register as present
// - five mode-select-high edges reset the port; identification instruction held after reset
// - serial input sampled on test-clock rise; serial output changes on its fall
// - instruction capture loads the pattern 01 into the two low bits
// - identification word loaded at data capture under identification, shifted during shift
package tap_pkg;

  // -------------------------------------------------------------------------
  // controller states, gray coded along the usual walk
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    st_reset     = 4'h0,
    st_idle      = 4'h1,
    st_sel_dr    = 4'h3,
    st_cap_dr    = 4'h2,
    st_shift_dr  = 4'h6,
    st_exit1_dr  = 4'h7,
    st_pause_dr  = 4'h5,
    st_exit2_dr  = 4'h4,
    st_upd_dr    = 4'hc,
    st_sel_ir    = 4'hd,
    st_cap_ir    = 4'hf,
    st_shift_ir  = 4'he,
    st_exit1_ir  = 4'ha,
    st_pause_ir  = 4'hb,
    st_exit2_ir  = 4'h9,
    st_upd_ir    = 4'h8
  } tap_state_type;

  // -------------------------------------------------------------------------
  // instructions and scan lengths
  // -------------------------------------------------------------------------
  localparam int       IR_LEN  = 3;
  localparam int       ID_LEN  = 32;
  localparam int       BSR_LEN = 32;
  localparam logic [2:0] INSTR_EXTEST   = 3'h0;
  localparam logic [2:0] INSTR_IDCODE   = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE   = 3'h4;
  localparam logic [2:0] INSTR_BYPASS   = 3'h7;
  localparam logic [2:0] IR_RESET       = INSTR_IDCODE;
  localparam logic [2:0] IR_CAPTURE     = 3'h1;

  // -------------------------------------------------------------------------
  // identification word: revision 31:28, depth 27:23, width 22:18,
  // part 17:12, maker 11:1, present 0
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  revision;
    logic [4:0]  depth;
    logic [4:0]  width;
    logic [5:0]  part;
    logic [10:0] maker;
    logic        present;
  } id_word_type;

  localparam int          ID_REVISION_LSB = 28;
  localparam int          ID_DEPTH_LSB    = 23;
  localparam int          ID_WIDTH_LSB    = 18;
  localparam int          ID_PART_LSB     = 12;
  localparam int          ID_MAKER_LSB    = 1;
  localparam logic [3:0]  RESET_REVISION  = 4'h0;
  localparam logic [4:0]  RESET_DEPTH     = 5'h00;
  localparam logic [4:0]  RESET_WIDTH     = 5'h00;
  localparam logic [5:0]  RESET_PART      = 6'h00;
  // arbitrary neutral maker code
  localparam logic [10:0] MAKER_CODE      = 11'h055;

  // -------------------------------------------------------------------------
  // pins from the test controller
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } pins_type;

  // -------------------------------------------------------------------------
  // apb register map
  // -------------------------------------------------------------------------
  localparam int          APB_AW       = 12;
  localparam logic [11:0] ADDR_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_IDWORD  = 12'h004;
  localparam logic [11:0] ADDR_IDCFG   = 12'h008;
  localparam logic [11:0] ADDR_CAPTURE = 12'h00c;
  localparam logic [31:0] RESET_IDCFG  = {RESET_REVISION, RESET_DEPTH, RESET_WIDTH,
                                          RESET_PART, 12'h000};

endpackage : tap_pkg

// *** verilog/pin_filter.sv ***
// module: three-stage synchroniser with agreement filter for test-port pins
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] held;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once stages two and three agree; the agreed value passes
  // on at once, so serial out follows a test-clock fall within four cycles
  always_comb begin
    level = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
    end else begin
      held <= level;
    end
  end

endmodule : pin_filter
`default_nettype wire

// *** verilog/tap_fsm.sv ***
// module: sixteen-state test-port controller advanced by test-clock rise pulses
`timescale 1ns/1ps
`default_nettype none
module tap_fsm (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // step pulse and mode select
  input  wire logic                   step,
  input  wire logic                   tms,
  // current state
  output var  tap_pkg::tap_state_type state
);

  function automatic tap_pkg::tap_state_type next_of(input tap_pkg::tap_state_type s,
                                                     input logic m);
    unique case (s)
      tap_pkg::st_reset:    next_of = m ? tap_pkg::st_reset   : tap_pkg::st_idle;
      tap_pkg::st_idle:     next_of = m ? tap_pkg::st_sel_dr  : tap_pkg::st_idle;
      tap_pkg::st_sel_dr:   next_of = m ? tap_pkg::st_sel_ir  : tap_pkg::st_cap_dr;
      tap_pkg::st_cap_dr:   next_of = m ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_shift_dr: next_of = m ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_exit1_dr: next_of = m ? tap_pkg::st_upd_dr  : tap_pkg::st_pause_dr;
      tap_pkg::st_pause_dr: next_of = m ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_exit2_dr: next_of = m ? tap_pkg::st_upd_dr  : tap_pkg::st_shift_dr;
      tap_pkg::st_upd_dr:   next_of = m ? tap_pkg::st_sel_dr  : tap_pkg::st_idle;
      tap_pkg::st_sel_ir:   next_of = m ? tap_pkg::st_reset   : tap_pkg::st_cap_ir;
      tap_pkg::st_cap_ir:   next_of = m ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_shift_ir: next_of = m ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_exit1_ir: next_of = m ? tap_pkg::st_upd_ir  : tap_pkg::st_pause_ir;
      tap_pkg::st_pause_ir: next_of = m ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_exit2_ir: next_of = m ? tap_pkg::st_upd_ir  : tap_pkg::st_shift_ir;
      tap_pkg::st_upd_ir:   next_of = m ? tap_pkg::st_sel_dr  : tap_pkg::st_idle;
      default:              next_of = tap_pkg::st_reset;
    endcase
  endfunction : next_of

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tap_pkg::st_reset;
    end else if (step) begin
      state <= next_of(state, tms);
    end
  end

endmodule : tap_fsm
`default_nettype wire

// *** verif/sram_tap_props.sv ***
// checker: port-level properties of the sram test port
`timescale 1ns/1ps
`default_nettype none
module sram_tap_props (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb slave
  input wire logic [tap_pkg::APB_AW-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // test port pins
  input wire logic                       tck,
  input wire logic                       tms,
  input wire logic                       tdi,
  input wire logic                       tdo_out,
  input wire logic                       tdo_oe,
  // sram side
  input wire logic [tap_pkg::BSR_LEN-1:0] pin_ring,
  input wire logic                       sram_hiz
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic st_rd;
  logic mapped;
  assign st_rd = pready && !pwrite && paddr == tap_pkg::ADDR_STATUS;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready late after setup");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  chk_bus_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_hiz_code: assert property (st_rd |-> prdata[7] == sram_hiz
    && prdata[7] == (prdata[6:4] inside {3'h0, 3'h2}))
    else $error("float control disagrees with instruction");
  chk_oe_idle: assert property (st_rd && prdata[3:1] == 3'h0 |-> !prdata[8] && !tdo_oe)
    else $error("serial out driven outside shift");
  chk_tdo_fall: assert property ($changed(tdo_out) |-> !tck)
    else $error("serial out changed while test clock high");
  chk_oe_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("serial enable changed while test clock high");
  chk_id_fields: assert property (pready && !pwrite && paddr == tap_pkg::ADDR_IDWORD
    |-> prdata[11:0] == {tap_pkg::MAKER_CODE, 1'b1})
    else $error("identification low fields wrong");
endmodule : sram_tap_props

bind sram_tap sram_tap_props i_sram_tap_props (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo_out, .tdo_oe,
  .pin_ring, .sram_hiz);
`default_nettype wire

// *** verif/tap_ctrl_model.sv ***
// partner: boundary-scan test controller driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module tap_ctrl_model (
  // clock
  input  wire logic pclk,
  // test port pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 160 ns test-clock period; tck rests low between frames, so the
  // caller always enters on a pclk edge and leaves on the next drive edge
  task automatic step(input logic m, input logic d, output logic q, output logic e);
    tms <= m;
    tdi <= d;
    @(posedge pclk);
    tck <= 1'b1;
    repeat (2) @(posedge pclk);
    tck <= 1'b0;
    // five pclk after the fall: the filtered output has settled by then
    repeat (5) @(posedge pclk);
    q = tdo_out;
    e = tdo_oe;
  endtask : step

  task automatic tap_reset();
    logic q;
    logic e;
    repeat (5) step(1'b1, 1'b0, q, e);
    step(1'b0, 1'b0, q, e);
  endtask : tap_reset

  // from idle: capture, shift code lsb first, update, back to idle
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    logic e;
    for (int j = 0; j < 4; j++) step(j < 2, 1'b0, cap[0], e);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], q, e);
      if (i < 2) cap[i + 1] = q;
    end
    step(1'b1, 1'b0, q, e);
    step(1'b0, 1'b0, q, e);
  endtask : load_ir

  task automatic scan(input logic [31:0] din, output logic [31:0] dout, output logic ok);
    logic q;
    logic e;
    step(1'b1, 1'b0, q, e);
    step(1'b0, 1'b0, q, e);
    step(1'b0, 1'b0, dout[0], ok);
    for (int i = 0; i < 32; i++) begin
      step(i == 31, din[i], q, e);
      if (i < 31) begin
        dout[i + 1] = q;
        ok = ok & e;
      end
    end
    step(1'b1, 1'b0, q, e);
    step(1'b0, 1'b0, q, e);
    ok = ok & !e;
  endtask : scan
endmodule : tap_ctrl_model
`default_nettype wire

// *** verif/sram_tap_tb.sv ***
// testbench: sram test port against a behavioural scan-chain model
`timescale 1ns/1ps
`default_nettype none
module sram_tap_tb;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pin_ring, cfg, ring, din, dout, r;
  logic        tck, tms, tdi, tdo_out, tdo_oe, sram_hiz, oe, er, hiz, bsr;
  logic [2:0]  code, cap;
  logic [2:0]  codes [8] = '{3'h1, 3'h7, 3'h2, 3'h4, 3'h7, 3'h4, 3'h2, 3'h0};
  int          errors, n_tests, seed, cycles;

  sram_tap i_sram_tap (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo_out, .tdo_oe, .pin_ring, .sram_hiz);
  tap_ctrl_model i_tap_ctrl (.pclk, .tck, .tms, .tdi, .tdo_out, .tdo_oe);

  always #10 pclk = ~pclk;

  // ---------------------------------------------------------------
  // model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] idw(input logic [31:0] c);
    return {c[31:12], tap_pkg::MAKER_CODE, 1'b1};
  endfunction : idw

  // chain of len captured bits, fed from din as bits leave
  function automatic logic [31:0] model_scan(int len, logic [31:0] c, logic [31:0] d);
    logic q[$];
    logic [31:0] o;
    for (int i = 0; i < len; i++) q.push_back(c[i]);
    for (int i = 0; i < 32; i++) begin
      o[i] = q.pop_front();
      q.push_back(d[i]);
    end
    return o;
  endfunction : model_scan

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait, or the bench timeout if pready never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, er}, {31'h0, err});
  endtask : rd

  task automatic stop_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, cycles, 0);
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pin_ring} = '0;
    {errors, n_tests, cycles} = '0;
    seed = 32'h91be1de1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(tap_pkg::ADDR_STATUS, 32'h10, 1'b0);
    rd(tap_pkg::ADDR_IDWORD, idw(32'h0), 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    apb(1'b1, tap_pkg::ADDR_STATUS, $random(seed));
    rd(tap_pkg::ADDR_STATUS, 32'h10, 1'b0);
    // leave the reset state for idle, where every scan task starts
    i_tap_ctrl.step(1'b0, 1'b0, oe, hiz);
    din = $random(seed);
    i_tap_ctrl.scan(din, dout, oe);
    chk(dout, model_scan(32, idw(32'h0), din));
    cfg = $random(seed);
    apb(1'b1, tap_pkg::ADDR_IDCFG, cfg);
    cfg = cfg & 32'hfffff000;
    rd(tap_pkg::ADDR_IDCFG, cfg, 1'b0);
    rd(tap_pkg::ADDR_IDWORD, idw(cfg), 1'b0);
    // every legal code; the controller never loads a reserved one
    for (int k = 0; k < 8; k++) begin
      code = codes[k];
      hiz = (code == 3'h0) || (code == 3'h2);
      bsr = hiz || (code == 3'h4);
      i_tap_ctrl.load_ir(code, cap);
      chk({29'h0, cap}, 32'h1);
      rd(tap_pkg::ADDR_STATUS, {23'h0, 1'b0, hiz, code, 4'h1}, 1'b0);
      chk({31'h0, sram_hiz}, {31'h0, hiz});
      ring = $random(seed);
      din = $random(seed);
      pin_ring <= ring;
      i_tap_ctrl.scan(din, dout, oe);
      chk(dout, model_scan((bsr || code == 3'h1) ? 32 : 1,
        bsr ? ring : (code == 3'h1 ? idw(cfg) : 32'h0), din));
      chk({31'h0, oe}, 32'h1);
      if (bsr) rd(tap_pkg::ADDR_CAPTURE, ring, 1'b0);
    end
    i_tap_ctrl.tap_reset();
    rd(tap_pkg::ADDR_STATUS, 32'h11, 1'b0);
    chk({31'h0, sram_hiz}, 32'h0);
    i_tap_ctrl.load_ir(3'h0, cap);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(tap_pkg::ADDR_STATUS, 32'h10, 1'b0);
    rd(tap_pkg::ADDR_IDCFG, 32'h0, 1'b0);
    stop_test();
  end
endmodule : sram_tap_tb
`default_nettype wire
